// *** hw/rss_pkg.sv ***
// Constants and types shared by the reset and start-up sequencer
package rss_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int RC_PERIOD_NS = 50;
    localparam int SETTLE_DELAY_NS = 72_000_000;
    localparam int SETTLE_TICKS = (SETTLE_DELAY_NS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
    localparam int OSC_STARTUP_CYCLES = 1024;
    localparam int CLR_FILTER_NS = 200;
    localparam int CLR_FILTER_CYCLES = (CLR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PC_W = 13;
    localparam logic [12:0] PC_RESET_VEC = 13'h0000;
    localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_CAUSE = 4'h8;
    localparam logic [3:0] OFS_PC = 4'hc;
    localparam int CTRL_SETTLE_BIT = 0;
    localparam int CTRL_OSC_LSB = 1;
    localparam int CTRL_IRQ_EN_BIT = 3;
    localparam int STAT_LOW_LSB = 0;
    localparam int STAT_POWERDOWN_BIT = 3;
    localparam int STAT_TIMEOUT_BIT = 4;
    localparam int STAT_BANK_LSB = 5;
    localparam int CAUSE_STATE_LSB = 4;
    localparam logic CTRL_SETTLE_RST = 1'b1;
    typedef enum logic [1:0] {
        RC_MODE = 2'h0,
        LOW_POWER_CRYSTAL_MODE = 2'h1,
        STANDARD_CRYSTAL_MODE = 2'h2,
        HIGH_SPEED_CRYSTAL_MODE = 2'h3
    } rss_osc_e;
    localparam rss_osc_e OSC_MODE_RST = RC_MODE;
    typedef enum logic [2:0] {
        ST_OFF = 3'h0, ST_HOLD = 3'h1, ST_DELAY = 3'h2, ST_RUN = 3'h3, ST_SLEEP = 3'h4
    } rss_state_e;
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0, CAUSE_POR = 3'h1, CAUSE_CLR_RUN = 3'h2, CAUSE_CLR_SLEEP = 3'h3,
        CAUSE_WDOG_RUN = 3'h4, CAUSE_WDOG_WAKE = 3'h5, CAUSE_IRQ_WAKE = 3'h6
    } rss_cause_e;
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0, PH_SETTLE = 2'h1, PH_OSC_STARTUP = 2'h2, PH_DONE = 2'h3
    } rss_phase_e;
endpackage : rss_pkg

// *** hw/rss_delay_if.sv ***
// Handshake between the sequencer and its delay chain
`timescale 1ns/1ps
interface rss_delay_if;
    logic start;
    logic settle_en;
    logic osc_startup_en;
    logic busy;
    logic done;
    modport seq (output start, output settle_en, output osc_startup_en, input busy, input done);
    modport chain (input start, input settle_en, input osc_startup_en, output busy, output done);
endinterface : rss_delay_if

// *** hw/rss_delay_chain.sv ***
// Supply-settle timer followed by oscillator start-up counter
`timescale 1ns/1ps
module rss_delay_chain #(
    parameter int SETTLE_TICKS = rss_pkg::SETTLE_TICKS,
    parameter int OSC_STARTUP_CYCLES = rss_pkg::OSC_STARTUP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic rc_osc_in,
    input wire logic osc_input_pin,
    rss_delay_if.chain dly
);
    localparam int MAXC = (SETTLE_TICKS > OSC_STARTUP_CYCLES) ? SETTLE_TICKS : OSC_STARTUP_CYCLES;
    localparam int CW = $clog2(MAXC + 1);
    localparam logic [CW-1:0] SET_LAST = CW'(SETTLE_TICKS - 1);
    localparam logic [CW-1:0] OSC_LAST = CW'(OSC_STARTUP_CYCLES - 1);
    rss_pkg::rss_phase_e phase_q;
    logic [CW-1:0] cnt_q;
    logic osc_en_q;
    logic rc_q;
    logic osc_q;
    logic rc_edge;
    logic osc_edge;
    assign rc_edge = rc_osc_in & ~rc_q;
    assign osc_edge = osc_input_pin & ~osc_q;
    assign dly.busy = (phase_q == rss_pkg::PH_SETTLE) || (phase_q == rss_pkg::PH_OSC_STARTUP);
    assign dly.done = (phase_q == rss_pkg::PH_DONE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rc_q <= 1'b0;
            osc_q <= 1'b0;
        end else if (ce) begin
            rc_q <= rc_osc_in;
            osc_q <= osc_input_pin;
        end
    end

    // A new start restarts the chain, so a fresh power-on mid-delay wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            phase_q <= rss_pkg::PH_IDLE;
            cnt_q <= '0;
            osc_en_q <= 1'b0;
        end else if (ce) begin
            if (dly.start) begin
                cnt_q <= '0;
                osc_en_q <= dly.osc_startup_en;
                if (dly.settle_en) begin
                    phase_q <= rss_pkg::PH_SETTLE;
                end else if (dly.osc_startup_en) begin
                    phase_q <= rss_pkg::PH_OSC_STARTUP;
                end else begin
                    phase_q <= rss_pkg::PH_DONE;
                end
            end else begin
                case (phase_q)
                    rss_pkg::PH_SETTLE: begin
                        if (rc_edge && cnt_q == SET_LAST) begin
                            cnt_q <= '0;
                            phase_q <= osc_en_q ? rss_pkg::PH_OSC_STARTUP : rss_pkg::PH_DONE;
                        end else if (rc_edge) begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    rss_pkg::PH_OSC_STARTUP: begin
                        if (osc_edge && cnt_q == OSC_LAST) begin
                            phase_q <= rss_pkg::PH_DONE;
                        end else if (osc_edge) begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    rss_pkg::PH_DONE: phase_q <= rss_pkg::PH_IDLE;
                    default: phase_q <= rss_pkg::PH_IDLE;
                endcase
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    settle_hold_a: assert property (
        ce && !dly.start && phase_q == rss_pkg::PH_SETTLE && !(rc_edge && cnt_q == SET_LAST)
        |=> phase_q == rss_pkg::PH_SETTLE) else $error("settle phase ended early");
    osc_count_a: assert property (
        ce && !dly.start && phase_q == rss_pkg::PH_OSC_STARTUP && osc_edge && cnt_q == OSC_LAST
        |=> dly.done) else $error("start-up count did not end at its last cycle");
    settle_skip_a: assert property (
        ce && dly.start && !dly.settle_en |=> phase_q != rss_pkg::PH_SETTLE)
        else $error("settle ran while disabled");
    no_delay_a: assert property (
        ce && dly.start && !dly.settle_en && !dly.osc_startup_en |=> dly.done)
        else $error("skipped chain did not finish at once");
    osc_run_c: cover property (phase_q == rss_pkg::PH_OSC_STARTUP ##1 dly.done);
endmodule : rss_delay_chain

// *** hw/rss_sequencer.sv ***
// Reset and start-up sequencer with Avalon-MM register slave
//
// What this block does
// - Distinguish six reset and wake causes
// - Filter glitches on external clear pin
// - Some register bits never reset
// - Others reset, except on sleep wake-ups
// - Program counter zero, or next on wake
// - Status flags updated per cause
// - Interrupt wake with enable loads vector
// - Rising supply makes power-on reset
// - Falling supply makes no reset
// - Settle timer counts internal RC ticks
// - Reset held while settle timer counts
// - Config bit enables settle timer
// - Start-up counts oscillator input cycles
// - Start-up only crystal modes, power-on/wake
// - Software cannot write status flags
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module rss_sequencer #(
    parameter int SETTLE_TICKS = rss_pkg::SETTLE_TICKS,
    parameter int OSC_STARTUP_CYCLES = rss_pkg::OSC_STARTUP_CYCLES,
    parameter int CLR_FILTER_CYCLES = rss_pkg::CLR_FILTER_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic supply_ok,
    input wire logic external_clear_pin_n,
    input wire logic watchdog_timeout,
    input wire logic irq_wake,
    input wire logic sleep_cmd,
    input wire logic clrwdog_cmd,
    input wire logic [12:0] pc_in,
    input wire logic rc_osc_in,
    input wire logic osc_input_pin,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic core_reset,
    output logic reg_reset,
    output logic core_asleep,
    output logic pc_load,
    output logic [12:0] pc_value,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic global_irq_enable
);
    localparam int FW = $clog2(CLR_FILTER_CYCLES + 1);
    localparam logic [FW-1:0] F_LAST = FW'(CLR_FILTER_CYCLES - 1);
    rss_delay_if dly ();
    rss_pkg::rss_state_e state_q, state_d;
    rss_pkg::rss_cause_e cause_q, cause_d;
    rss_pkg::rss_osc_e osc_mode_q;
    logic kind_rst_q, kind_rst_d;
    logic [12:0] pc_tgt_q, pc_tgt_d;
    logic supply_q;
    logic clr_low_q;
    logic [FW-1:0] fcnt_q;
    logic por_p, clr_ev, wdog_run, wdog_wake, irq_ev, slp_ev, clrwdog_ev;
    logic rst_ev, flag_ev, rel, crystal;
    logic timeout_flag_q, powerdown_flag_q;
    logic settle_en_q, irq_en_q;
    logic [2:0] bank_q;
    logic [2:0] st_low_q;
    logic ack_q, wr_en, wr_ctrl, wr_stat;
    logic [31:0] rd_mux, readdata_q;
    logic core_reset_q, reg_reset_q, core_asleep_q, pc_load_q;

    rss_delay_chain #(
        .SETTLE_TICKS(SETTLE_TICKS),
        .OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES)
    ) u_chain (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .rc_osc_in(rc_osc_in),
        .osc_input_pin(osc_input_pin),
        .dly(dly.chain)
    );

    // Supply edge; only the rising edge counts, a drop is ignored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            supply_q <= 1'b0;
        end else if (ce) begin
            supply_q <= supply_ok;
        end
    end
    assign por_p = ce & supply_ok & ~supply_q;

    // Pin must hold a new level for the full count before it is believed
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clr_low_q <= 1'b0;
            fcnt_q <= '0;
        end else if (ce) begin
            if (~external_clear_pin_n == clr_low_q) begin
                fcnt_q <= '0;
            end else if (fcnt_q == F_LAST) begin
                clr_low_q <= ~external_clear_pin_n;
                fcnt_q <= '0;
            end else begin
                fcnt_q <= fcnt_q + 1'b1;
            end
        end
    end

    // Cause decode, power-on first, then pin, then watchdog
    assign clr_ev = ce & ~por_p & clr_low_q &
        (state_q == rss_pkg::ST_RUN || state_q == rss_pkg::ST_SLEEP);
    assign wdog_run = ce & ~por_p & ~clr_low_q & watchdog_timeout & (state_q == rss_pkg::ST_RUN);
    assign wdog_wake = ce & ~por_p & ~clr_low_q & watchdog_timeout &
        (state_q == rss_pkg::ST_SLEEP);
    assign irq_ev = ce & ~por_p & ~clr_low_q & ~watchdog_timeout & irq_wake &
        (state_q == rss_pkg::ST_SLEEP);
    assign slp_ev = ce & ~por_p & ~clr_low_q & ~watchdog_timeout & sleep_cmd &
        (state_q == rss_pkg::ST_RUN);
    assign clrwdog_ev = ce & ~por_p & ~clr_low_q & ~watchdog_timeout & ~sleep_cmd &
        clrwdog_cmd & (state_q == rss_pkg::ST_RUN);
    assign rst_ev = por_p | clr_ev | wdog_run;
    assign flag_ev = rst_ev | wdog_wake | irq_ev | slp_ev | clrwdog_ev;
    assign crystal = (osc_mode_q != rss_pkg::RC_MODE);
    assign dly.start = por_p | wdog_run | wdog_wake | irq_ev;
    assign dly.settle_en = por_p & settle_en_q;
    assign dly.osc_startup_en = crystal & (por_p | wdog_wake | irq_ev);
    assign rel = ce & ~por_p & ~clr_low_q &
        ((state_q == rss_pkg::ST_HOLD) || (state_q == rss_pkg::ST_DELAY && dly.done));

    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        kind_rst_d = kind_rst_q;
        pc_tgt_d = pc_tgt_q;
        if (por_p) begin
            state_d = rss_pkg::ST_DELAY;
            cause_d = rss_pkg::CAUSE_POR;
            kind_rst_d = 1'b1;
            pc_tgt_d = rss_pkg::PC_RESET_VEC;
        end else if (clr_ev) begin
            state_d = rss_pkg::ST_HOLD;
            cause_d = (state_q == rss_pkg::ST_SLEEP) ? rss_pkg::CAUSE_CLR_SLEEP :
                rss_pkg::CAUSE_CLR_RUN;
            kind_rst_d = 1'b1;
            pc_tgt_d = rss_pkg::PC_RESET_VEC;
        end else if (wdog_run) begin
            state_d = rss_pkg::ST_DELAY;
            cause_d = rss_pkg::CAUSE_WDOG_RUN;
            kind_rst_d = 1'b1;
            pc_tgt_d = rss_pkg::PC_RESET_VEC;
        end else if (wdog_wake) begin
            state_d = rss_pkg::ST_DELAY;
            cause_d = rss_pkg::CAUSE_WDOG_WAKE;
            kind_rst_d = 1'b0;
            pc_tgt_d = pc_in + 13'h0001;
        end else if (irq_ev) begin
            state_d = rss_pkg::ST_DELAY;
            cause_d = rss_pkg::CAUSE_IRQ_WAKE;
            kind_rst_d = 1'b0;
            pc_tgt_d = irq_en_q ? rss_pkg::PC_IRQ_VEC : pc_in + 13'h0001;
        end else if (ce) begin
            case (state_q)
                rss_pkg::ST_HOLD: begin
                    if (!clr_low_q) state_d = rss_pkg::ST_RUN;
                end
                rss_pkg::ST_DELAY: begin
                    if (dly.done) state_d = clr_low_q ? rss_pkg::ST_HOLD : rss_pkg::ST_RUN;
                end
                rss_pkg::ST_RUN: begin
                    if (slp_ev) state_d = rss_pkg::ST_SLEEP;
                end
                default: state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= rss_pkg::ST_OFF;
            cause_q <= rss_pkg::CAUSE_NONE;
            kind_rst_q <= 1'b1;
            pc_tgt_q <= rss_pkg::PC_RESET_VEC;
            core_reset_q <= 1'b1;
            core_asleep_q <= 1'b0;
            reg_reset_q <= 1'b0;
            pc_load_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cause_q <= cause_d;
            kind_rst_q <= kind_rst_d;
            pc_tgt_q <= pc_tgt_d;
            // Reset stays up through every delay of a reset cause
            core_reset_q <= (state_d == rss_pkg::ST_OFF) || (state_d == rss_pkg::ST_HOLD) ||
                (state_d == rss_pkg::ST_DELAY && kind_rst_d);
            core_asleep_q <= (state_d == rss_pkg::ST_SLEEP);
            reg_reset_q <= rst_ev;
            pc_load_q <= rel;
        end
    end

    // Flags belong to hardware alone; no bus path reaches them
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timeout_flag_q <= 1'b1;
            powerdown_flag_q <= 1'b1;
        end else if (flag_ev) begin
            if (por_p || clrwdog_ev) begin
                timeout_flag_q <= 1'b1;
                powerdown_flag_q <= 1'b1;
            end else if (clr_ev) begin
                if (state_q == rss_pkg::ST_SLEEP) begin
                    timeout_flag_q <= 1'b1;
                    powerdown_flag_q <= 1'b0;
                end
            end else if (wdog_run) begin
                timeout_flag_q <= 1'b0;
                powerdown_flag_q <= 1'b1;
            end else if (wdog_wake) begin
                timeout_flag_q <= 1'b0;
                powerdown_flag_q <= 1'b0;
            end else begin
                timeout_flag_q <= 1'b1;
                powerdown_flag_q <= 1'b0;
            end
        end
    end

    // Avalon slave: one wait state, then write lands and read data stands
    assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & ce);
    assign wr_en = avs_write & ack_q & ce;
    assign wr_ctrl = wr_en && (avs_address == rss_pkg::OFS_CTRL);
    assign wr_stat = wr_en && (avs_address == rss_pkg::OFS_STATUS);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else if (ce) begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (avs_read && !ack_q) readdata_q <= rd_mux;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address == rss_pkg::OFS_CTRL) begin
            rd_mux[rss_pkg::CTRL_SETTLE_BIT] = settle_en_q;
            rd_mux[rss_pkg::CTRL_OSC_LSB +: 2] = osc_mode_q;
            rd_mux[rss_pkg::CTRL_IRQ_EN_BIT] = irq_en_q;
        end else if (avs_address == rss_pkg::OFS_STATUS) begin
            rd_mux[rss_pkg::STAT_LOW_LSB +: 3] = st_low_q;
            rd_mux[rss_pkg::STAT_POWERDOWN_BIT] = powerdown_flag_q;
            rd_mux[rss_pkg::STAT_TIMEOUT_BIT] = timeout_flag_q;
            rd_mux[rss_pkg::STAT_BANK_LSB +: 3] = bank_q;
        end else if (avs_address == rss_pkg::OFS_CAUSE) begin
            rd_mux[2:0] = cause_q;
            rd_mux[rss_pkg::CAUSE_STATE_LSB +: 3] = state_q;
        end else if (avs_address == rss_pkg::OFS_PC) begin
            rd_mux[12:0] = pc_tgt_q;
        end
    end

    // Settle enable and oscillator mode survive every device reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            settle_en_q <= rss_pkg::CTRL_SETTLE_RST;
            osc_mode_q <= rss_pkg::OSC_MODE_RST;
        end else if (wr_ctrl) begin
            settle_en_q <= avs_writedata[rss_pkg::CTRL_SETTLE_BIT];
            osc_mode_q <= rss_pkg::rss_osc_e'(avs_writedata[rss_pkg::CTRL_OSC_LSB +: 2]);
        end
    end

    // Reset-state bits; wake-ups leave them alone
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_en_q <= 1'b0;
            bank_q <= 3'h0;
        end else if (rst_ev) begin
            irq_en_q <= 1'b0;
            bank_q <= 3'h0;
        end else begin
            if (wr_ctrl) irq_en_q <= avs_writedata[rss_pkg::CTRL_IRQ_EN_BIT];
            if (wr_stat) bank_q <= avs_writedata[rss_pkg::STAT_BANK_LSB +: 3];
        end
    end

    // No reset at all: unknown after power-up, kept across every cause
    always_ff @(posedge ref_clk) begin
        if (wr_stat) st_low_q <= avs_writedata[rss_pkg::STAT_LOW_LSB +: 3];
    end

    assign avs_readdata = readdata_q;
    assign core_reset = core_reset_q;
    assign reg_reset = reg_reset_q;
    assign core_asleep = core_asleep_q;
    assign pc_load = pc_load_q;
    assign pc_value = pc_tgt_q;
    assign timeout_flag = timeout_flag_q;
    assign powerdown_flag = powerdown_flag_q;
    assign global_irq_enable = irq_en_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    por_flags_a: assert property (
        por_p |=> timeout_flag_q && powerdown_flag_q && core_reset_q &&
        cause_q == rss_pkg::CAUSE_POR) else $error("power-on did not set flags and reset");
    supply_fall_a: assert property (
        ce && supply_q && !supply_ok && state_q == rss_pkg::ST_RUN && !clr_low_q &&
        !watchdog_timeout && !sleep_cmd |=> state_q == rss_pkg::ST_RUN && !core_reset_q)
        else $error("falling supply caused a reset");
    clr_filter_a: assert property (
        $rose(clr_low_q) |-> $past(!external_clear_pin_n, 1) && $past(!external_clear_pin_n, 2)
        && $past(!external_clear_pin_n, 3) && $past(!external_clear_pin_n, 4)
        || !($past(ce, 2) && $past(ce, 3) && $past(ce, 4)))
        else $error("clear pin accepted a short pulse");
    cause_sleep_a: assert property (
        clr_ev && state_q == rss_pkg::ST_SLEEP |=> cause_q == rss_pkg::CAUSE_CLR_SLEEP &&
        timeout_flag_q && !powerdown_flag_q) else $error("clear in sleep misreported");
    low_keep_a: assert property (
        rst_ev && !wr_stat |=> st_low_q === $past(st_low_q)) else $error("unreset bits changed");
    wake_keep_a: assert property (
        (wdog_wake || irq_ev) |=> $stable(bank_q) && $stable(irq_en_q) && !reg_reset_q)
        else $error("wake-up disturbed reset-state bits");
    pc_zero_a: assert property (
        pc_load_q && kind_rst_q |-> pc_value == rss_pkg::PC_RESET_VEC)
        else $error("reset released with nonzero program counter");
    wake_flags_a: assert property (
        wdog_wake |=> !timeout_flag_q && !powerdown_flag_q ##1 !core_reset_q)
        else $error("watchdog wake flags wrong");
    irq_vec_a: assert property (
        irq_ev && irq_en_q |=> pc_tgt_q == rss_pkg::PC_IRQ_VEC)
        else $error("interrupt wake missed the vector");
    settle_hold_a: assert property (
        dly.busy && kind_rst_q |-> core_reset_q) else $error("reset dropped during delay");
    sw_flags_a: assert property (
        ($changed(timeout_flag_q) || $changed(powerdown_flag_q)) |-> $past(flag_ev))
        else $error("flags changed without a hardware event");
    release_a: assert property (
        $fell(core_reset_q) |-> state_q == rss_pkg::ST_RUN && !dly.busy && !clr_low_q)
        else $error("reset released before delays completed");
    por_run_c: cover property (por_p ##[1:40] pc_load_q);
    wdog_wake_c: cover property (wdog_wake ##[1:40] pc_load_q);
    irq_vec_c: cover property (irq_ev && irq_en_q ##[1:40] pc_load_q);
endmodule : rss_sequencer

// *** sim/rss_far_side.sv ***
// Far-side model: supply detector, clear pin and oscillators
`timescale 1ns/1ps
module rss_far_side (
    input wire logic ref_clk,
    input wire logic power_up,
    input wire logic clear_hold,
    output logic supply_ok,
    output logic external_clear_pin_n,
    output logic rc_osc_in,
    output logic osc_input_pin
);
    initial begin
        rc_osc_in = 1'b0;
        osc_input_pin = 1'b0;
        supply_ok = 1'b0;
        external_clear_pin_n = 1'b1;
    end
    // Slower than ref_clk so every rising edge gets sampled
    always #100 rc_osc_in = ~rc_osc_in;
    // Period chosen so no toggle lands on a rising ref_clk edge
    always #80 osc_input_pin = ~osc_input_pin;
    always @(posedge ref_clk) begin
        supply_ok <= power_up;
        external_clear_pin_n <= ~clear_hold;
    end
endmodule : rss_far_side

// *** sim/tb.sv ***
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, srst = 1'b1, power_up = 1'b0, clear_hold = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, core_reset, reg_reset;
    logic core_asleep, pc_load, timeout_flag, powerdown_flag, global_irq_enable;
    logic supply_ok, clr_n, rc, osc;
    logic [3:0] evs = 4'h0, avs_address = 4'h0;
    logic [12:0] pc_in = 13'h0000, pc_value;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    int n_errors = 0, n_tests = 0, seed = 71087;
    int n_rr = 0;
    always #25 ref_clk = ~ref_clk;
    // Pulse counter, sampled mid-cycle where the output is settled
    always @(negedge ref_clk) if (reg_reset === 1'b1) n_rr++;
    rss_far_side rss_far_side_inst (.ref_clk(ref_clk), .power_up(power_up),
        .clear_hold(clear_hold), .supply_ok(supply_ok), .external_clear_pin_n(clr_n),
        .rc_osc_in(rc), .osc_input_pin(osc));
    rss_sequencer #(.SETTLE_TICKS(8), .OSC_STARTUP_CYCLES(4), .CLR_FILTER_CYCLES(4))
        rss_sequencer_inst (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .supply_ok(supply_ok),
        .external_clear_pin_n(clr_n), .watchdog_timeout(evs[2]), .irq_wake(evs[1]),
        .sleep_cmd(evs[0]), .clrwdog_cmd(evs[3]), .pc_in(pc_in), .rc_osc_in(rc),
        .osc_input_pin(osc), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_reset(core_reset), .reg_reset(reg_reset),
        .core_asleep(core_asleep), .pc_load(pc_load), .pc_value(pc_value),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .global_irq_enable(global_irq_enable));
    task automatic final_report;
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_word(what, {31'h0, exp}, {31'h0, got});
    endtask : cmp_bit
    task automatic stall;
        n_errors++;
        final_report();
    endtask : stall
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) stall();
    endtask : bus
    task automatic ev(input int k);
        @(posedge ref_clk);
        evs <= 4'h1 << k;
        @(posedge ref_clk);
        evs <= 4'h0;
    endtask : ev
    task automatic stay_up(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            cmp_bit("core_reset", 1'b0, core_reset);
        end
    endtask : stay_up
    task automatic release_chk(input logic [12:0] pc, input logic to, input logic pd);
        for (int i = 0; i < 3000 && pc_load !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (pc_load !== 1'b1) stall();
        cmp_word("pc_value", {19'h0, pc}, {19'h0, pc_value});
        cmp_bit("core_reset", 1'b0, core_reset);
        cmp_bit("timeout_flag", to, timeout_flag);
        cmp_bit("powerdown_flag", pd, powerdown_flag);
        bus(1'b0, 4'h4, 32'h0);
        cmp_word("status flags", {27'h0, to, pd, 3'h0}, rd & 32'h18);
    endtask : release_chk
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        power_up <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        cmp_bit("core_reset", 1'b1, core_reset);
        release_chk(13'h0000, 1'b1, 1'b1);
        bus(1'b1, 4'h0, 32'hd);
        bus(1'b0, 4'h0, 32'h0);
        cmp_word("ctrl", 32'hd, rd);
        bus(1'b1, 4'h4, 32'he5);
        bus(1'b0, 4'h6, 32'h0);
        cmp_word("unmapped", 32'h0, rd);
        bus(1'b0, 4'h4, 32'h0);
        cmp_word("status", 32'hfd, rd);
        ev(0);
        repeat (2) @(posedge ref_clk);
        #1;
        cmp_bit("core_asleep", 1'b1, core_asleep);
        ev(1);
        release_chk(13'h0004, 1'b1, 1'b0);
        pc_in <= 13'($random(seed));
        ev(0);
        repeat (2) @(posedge ref_clk);
        ev(2);
        release_chk(pc_in + 13'h1, 1'b0, 1'b0);
        cmp_word("status", 32'he5, rd);
        cmp_bit("global_irq_enable", 1'b1, global_irq_enable);
        cmp_word("reg_reset pulses", 32'h1, n_rr);
        ev(2);
        release_chk(13'h0000, 1'b0, 1'b1);
        cmp_word("status", 32'h0d, rd);
        cmp_bit("global_irq_enable", 1'b0, global_irq_enable);
        // Three low samples stay below the filter length
        clear_hold <= 1'b1;
        repeat (3) @(posedge ref_clk);
        clear_hold <= 1'b0;
        stay_up(12);
        clear_hold <= 1'b1;
        repeat (8) @(posedge ref_clk);
        clear_hold <= 1'b0;
        release_chk(13'h0000, 1'b0, 1'b1);
        bus(1'b0, 4'h0, 32'h0);
        cmp_word("ctrl", 32'h5, rd);
        ev(3);
        bus(1'b0, 4'h4, 32'h0);
        cmp_word("status", 32'h1d, rd);
        // Clear pin while asleep: reset with powerdown cleared
        ev(0);
        clear_hold <= 1'b1;
        repeat (8) @(posedge ref_clk);
        clear_hold <= 1'b0;
        release_chk(13'h0000, 1'b1, 1'b0);
        power_up <= 1'b0;
        stay_up(20);
        // Second power-on with settle off, crystal start-up only
        bus(1'b1, 4'h0, 32'h4);
        power_up <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        cmp_bit("core_reset", 1'b1, core_reset);
        release_chk(13'h0000, 1'b1, 1'b1);
        cmp_word("reg_reset pulses", 32'h5, n_rr);
        final_report();
    end
endmodule : tb
